// >>> prwt_pkg.sv
/*
 * Package for the periodic reset wake-up timer: register map, field positions,
 * reset values, mode encodings and bus carrier types.
 * Assumes a 32-bit AXI4-Lite register bus and one 25 MHz clock.
 */
package prwt_pkg;

	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam logic [7:0] PRWT_ADDR_PERIODIC_RESET_CONTROL_STATUS = 8'h3a;
	localparam logic [7:0] PRWT_ADDR_WAKEUP_CONTROL_STATUS         = 8'h39;
	localparam logic [7:0] PRWT_IDX_PERIODIC_RESET_CONTROL_STATUS  = PRWT_ADDR_PERIODIC_RESET_CONTROL_STATUS;
	localparam logic [7:0] PRWT_IDX_WAKEUP_CONTROL_STATUS          = PRWT_ADDR_WAKEUP_CONTROL_STATUS;
	localparam logic [7:0] PRWT_IDX_MODE_CONTROL                   = 8'h40;
	localparam logic [7:0] PRWT_IDX_UNIT_STATUS                    = 8'h41;

	// -----------------------------------------------------------------
	// Field positions and reset values
	// -----------------------------------------------------------------
	localparam int         PRWT_FLAG_BIT        = 7;
	localparam int         PRWT_CLEAR_BIT       = 6;
	localparam int         PRWT_INTERVAL_MSB    = 5;
	localparam int         PRWT_INTERVAL_W      = 6;
	localparam logic [5:0] PRWT_INTERVAL_RESET  = 6'h3f;
	localparam logic [5:0] PRWT_PRESCALE_RESET  = 6'h3f;
	localparam logic [1:0] PRWT_AXI_OKAY        = 2'h0;
	localparam logic [1:0] PRWT_AXI_DECERR      = 2'h3;

	// -----------------------------------------------------------------
	// Power modes
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		PRWT_MODE_RUN_WAIT,
		PRWT_MODE_LIGHT_STOP,
		PRWT_MODE_DEEP_STOP
	} prwt_mode_t;

	// Events presented to the CPU core, reset and interrupt logic.
	typedef struct packed {
		logic wakeup_irq;
		logic periodic_reset;
		logic clock_restart;
		logic deep_stop_por_exit;
		logic deep_stop_por_only;
	} prwt_event_t;

endpackage

// >>> prwt_timer.sv
/*
 * Periodic reset wake-up timer: prescaler, wake-up interval counter and
 * periodic reset counter behind an AXI4-Lite slave.
 * Assumes the slow tick, power mode and debug state come from logic on aclk;
 * the tick is one aclk cycle wide per slow clock period.
 */
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps


module prwt_timer
	import prwt_pkg::*;
#(
	parameter int INTERVAL_W = 6
) (
	// Clock and resets
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 por_n,
	// AXI4-Lite write address
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [7:0]           s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	// AXI4-Lite write response
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	output logic [1:0]                s_axi_bresp,
	// AXI4-Lite read
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	input  wire logic [7:0]           s_axi_araddr,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	// System side
	input  wire logic                 slow_tick,
	input  wire prwt_pkg::prwt_mode_t power_mode,
	input  wire logic                 debug_active,
	input  wire logic                 interrupt_unmask_instruction,
	output prwt_pkg::prwt_event_t     events
);
	import prwt_pkg::*;

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	logic                  periodic_reset_flag;
	logic                  wakeup_flag;
	logic [INTERVAL_W-1:0] reset_interval_count;
	logic [INTERVAL_W-1:0] wakeup_interval_count;
	logic [5:0]            wakeup_prescale_divider;
	logic [5:0]            prescale_cnt;
	logic [INTERVAL_W-1:0] wakeup_cnt;
	logic [INTERVAL_W-1:0] reset_cnt;
	logic                  deep_wake_pending;
	logic                  aw_held;
	logic                  w_held;
	logic [7:0]            aw_addr;
	logic [31:0]           w_data;
	logic [3:0]            w_strb;
	logic                  wr_fire;
	logic                  run;
	logic                  prescale_done;
	logic                  wakeup_event;
	logic                  reset_event;
	logic                  restart;
	logic [INTERVAL_W-1:0] wr_reset_iv;
	logic [INTERVAL_W-1:0] wr_wake_iv;
	logic                  wr_reset_reg;
	logic                  wr_wake_reg;
	logic                  reset_iv_change;
	logic                  wake_iv_change;

	// -----------------------------------------------------------------
	// AXI4-Lite write path
	// -----------------------------------------------------------------
	// Address and data may arrive in either order; each is held until both are present.
	// The response waits for both halves, so a lone address never commits a stale data word.
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= PRWT_AXI_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr[7:2] == PRWT_IDX_PERIODIC_RESET_CONTROL_STATUS[5:0]
				|| aw_addr[7:2] == PRWT_IDX_WAKEUP_CONTROL_STATUS[5:0]
				|| aw_addr[7:2] == PRWT_IDX_MODE_CONTROL[5:0]
				|| aw_addr[7:2] == PRWT_IDX_UNIT_STATUS[5:0]) ? PRWT_AXI_OKAY : PRWT_AXI_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Word addresses are four times the printed index; only the low six index bits decode.
	assign wr_reset_reg    = wr_fire && w_strb[0] && aw_addr[1:0] == 2'h0
		&& aw_addr[7:2] == PRWT_IDX_PERIODIC_RESET_CONTROL_STATUS[5:0];
	assign wr_wake_reg     = wr_fire && w_strb[0] && aw_addr[1:0] == 2'h0
		&& aw_addr[7:2] == PRWT_IDX_WAKEUP_CONTROL_STATUS[5:0];
	assign wr_reset_iv     = w_data[INTERVAL_W-1:0];
	assign wr_wake_iv      = w_data[INTERVAL_W-1:0];
	// An all-zero write is refused while the other interval is already zero.
	// A refused write still answers OKAY; software reads back to learn that the old value was kept.
	assign reset_iv_change = wr_reset_reg && wr_reset_iv != reset_interval_count
		&& !(wr_reset_iv == '0 && wakeup_interval_count == '0);
	assign wake_iv_change  = wr_wake_reg && wr_wake_iv != wakeup_interval_count
		&& !(wr_wake_iv == '0 && reset_interval_count == '0);
	assign restart         = reset_iv_change || wake_iv_change;

	// -----------------------------------------------------------------
	// Control registers
	// -----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_interval_count  <= INTERVAL_W'(PRWT_INTERVAL_RESET);
			wakeup_interval_count <= INTERVAL_W'(PRWT_INTERVAL_RESET);
		end else begin
			if (reset_iv_change) begin
				reset_interval_count <= wr_reset_iv;
			end
			if (wake_iv_change) begin
				wakeup_interval_count <= wr_wake_iv;
			end
		end
	end

	// Divider value set at the mode control word; a zero wake-up interval forces it to full scale.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wakeup_prescale_divider <= PRWT_PRESCALE_RESET;
		end else if (wr_fire && w_strb[0] && aw_addr[7:2] == PRWT_IDX_MODE_CONTROL[5:0]) begin
			wakeup_prescale_divider <= w_data[5:0];
		end else if (wake_iv_change && wr_wake_iv == '0) begin
			wakeup_prescale_divider <= PRWT_PRESCALE_RESET;
		end
	end

	// The periodic reset flag survives aresetn; only power-on reset clears it.
	// The set wins over an acknowledge that lands in the same cycle.
	always_ff @(posedge aclk) begin
		if (!por_n) begin
			periodic_reset_flag <= 1'b0;
		end else if (reset_event) begin
			periodic_reset_flag <= 1'b1;
		end else if (wr_reset_reg && w_data[PRWT_CLEAR_BIT]) begin
			periodic_reset_flag <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wakeup_flag <= 1'b0;
		end else if (wakeup_event) begin
			wakeup_flag <= 1'b1;
		end else if (wr_wake_reg && w_data[PRWT_CLEAR_BIT]) begin
			wakeup_flag <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Counters
	// -----------------------------------------------------------------
	// Debug holds every count; nothing is cleared, so counting resumes in place.
	// The wake-up period is the only clock of the reset counter, so a disabled wake-up also stops resets.
	assign run           = !debug_active;
	assign prescale_done = run && slow_tick && prescale_cnt >= wakeup_prescale_divider;
	assign wakeup_event  = prescale_done && wakeup_interval_count != '0
		&& wakeup_cnt + 1'b1 >= wakeup_interval_count;
	assign reset_event   = wakeup_event && reset_interval_count != '0
		&& reset_cnt + 1'b1 >= reset_interval_count;

	// A restart wins over a tick in the same cycle, so a new interval always counts from zero.
	always_ff @(posedge aclk) begin
		if (!aresetn || restart) begin
			prescale_cnt <= 6'h00;
			wakeup_cnt   <= '0;
			reset_cnt    <= '0;
		end else if (run && slow_tick) begin
			prescale_cnt <= prescale_done ? 6'h00 : prescale_cnt + 6'h01;
			if (prescale_done) begin
				wakeup_cnt <= wakeup_event ? '0 : wakeup_cnt + 1'b1;
			end
			if (wakeup_event) begin
				reset_cnt <= reset_event ? '0 : reset_cnt + 1'b1;
			end
		end
	end

	// -----------------------------------------------------------------
	// Mode-dependent system events
	// -----------------------------------------------------------------
	// A deep-stop wake-up is remembered across the power-on exit until software unmasks.
	// Deep stop is left through a power-on sequence, so no periodic reset pulse is sent there.
	always_ff @(posedge aclk) begin
		if (!por_n) begin
			deep_wake_pending <= 1'b0;
		end else if (wakeup_event && power_mode == PRWT_MODE_DEEP_STOP) begin
			deep_wake_pending <= 1'b1;
		end else if (interrupt_unmask_instruction) begin
			deep_wake_pending <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			events <= '0;
		end else begin
			events.wakeup_irq         <= (wakeup_event && power_mode != PRWT_MODE_DEEP_STOP)
				|| (deep_wake_pending && interrupt_unmask_instruction);
			events.periodic_reset     <= reset_event && power_mode != PRWT_MODE_DEEP_STOP;
			events.clock_restart      <= (wakeup_event || reset_event)
				&& power_mode == PRWT_MODE_LIGHT_STOP;
			events.deep_stop_por_exit <= (wakeup_event || reset_event)
				&& power_mode == PRWT_MODE_DEEP_STOP;
			events.deep_stop_por_only <= reset_event && power_mode == PRWT_MODE_DEEP_STOP;
		end
	end
	// Programmed intervals sit on aresetn, so the resets this unit causes return them to 63.

	// -----------------------------------------------------------------
	// AXI4-Lite read path
	// -----------------------------------------------------------------
	// One read at a time: the address channel stays closed while read data waits for the master.
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= PRWT_AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= PRWT_AXI_OKAY;
			s_axi_rdata  <= 32'h0000_0000;
			case (s_axi_araddr[7:2])
				PRWT_IDX_PERIODIC_RESET_CONTROL_STATUS[5:0]: begin
					// Clear bit always reads zero.
					s_axi_rdata <= {24'h00_0000, periodic_reset_flag, 1'b0,
						6'(reset_interval_count)};
				end
				PRWT_IDX_WAKEUP_CONTROL_STATUS[5:0]: begin
					s_axi_rdata <= {24'h00_0000, wakeup_flag, 1'b0, 6'(wakeup_interval_count)};
				end
				PRWT_IDX_MODE_CONTROL[5:0]: begin
					s_axi_rdata <= {26'h000_0000, wakeup_prescale_divider};
				end
				PRWT_IDX_UNIT_STATUS[5:0]: begin
					s_axi_rdata <= {24'h00_0000, 2'h0, 6'(reset_cnt)};
				end
				default: begin
					s_axi_rresp <= PRWT_AXI_DECERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	// Flag checks are gated by power-on reset only, since the flag ignores the bus reset.
	property p_flag_set;
		@(posedge aclk) disable iff (!por_n) reset_event |=> periodic_reset_flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("reset flag not set");

	property p_flag_write;
		@(posedge aclk) disable iff (!por_n)
			(wr_reset_reg && !w_data[PRWT_CLEAR_BIT] && !reset_event) |=> $stable(periodic_reset_flag);
	endproperty
	a_flag_write: assert property (p_flag_write) else $error("flag changed by write");

	property p_flag_clear;
		@(posedge aclk) disable iff (!por_n)
			(wr_reset_reg && w_data[PRWT_CLEAR_BIT] && !reset_event) |=> !periodic_reset_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	property p_flag_keep;
		@(posedge aclk) disable iff (!por_n) (!aresetn && periodic_reset_flag) |=> periodic_reset_flag;
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("flag lost on reset");

	property p_interval_reset;
		@(posedge aclk) !aresetn |=> reset_interval_count == INTERVAL_W'(PRWT_INTERVAL_RESET);
	endproperty
	a_interval_reset: assert property (p_interval_reset) else $error("interval not 63");

	property p_no_both_zero;
		@(posedge aclk) disable iff (!aresetn)
			!(reset_interval_count == '0 && wakeup_interval_count == '0);
	endproperty
	a_no_both_zero: assert property (p_no_both_zero) else $error("both intervals zero");

	property p_same_value;
		@(posedge aclk) disable iff (!aresetn)
			(wr_reset_reg && wr_reset_iv == reset_interval_count && !wake_iv_change) |-> !restart;
	endproperty
	a_same_value: assert property (p_same_value) else $error("restart on same value");

	property p_freeze;
		@(posedge aclk) disable iff (!aresetn)
			(debug_active && !restart) |=> $stable(prescale_cnt) && $stable(reset_cnt);
	endproperty
	a_freeze: assert property (p_freeze) else $error("count moved in debug");

	property p_deep_por;
		@(posedge aclk) disable iff (!aresetn)
			(reset_event && power_mode == PRWT_MODE_DEEP_STOP) |=> events.deep_stop_por_exit
				&& !events.periodic_reset;
	endproperty
	a_deep_por: assert property (p_deep_por) else $error("deep stop exit wrong");

endmodule

// >>> prwt_partner.sv
/*
 * Far-side model of the periodic reset wake-up timer: a slow tick source and
 * an observer that counts the event pulses sent to core, reset and interrupt logic.
 * Assumes one aclk domain and event pulses one cycle wide.
 */
`timescale 1ns/10ps

module prwt_partner (
	// Clock
	input  wire logic                  aclk,
	// Tick requests
	input  wire logic                  tick_load,
	input  wire logic [7:0]            tick_total,
	output logic                       tick_busy,
	output logic                       slow_tick,
	// Event observation
	input  wire prwt_pkg::prwt_event_t events,
	input  wire logic                  count_clear,
	output logic [4:0][7:0]            seen
);
	import prwt_pkg::*;

	logic [7:0] left = 8'h00;
	logic [1:0] gap  = 2'h0;

	// Ticks are spaced four cycles apart, as a slow clock would be.
	assign slow_tick = (left != 8'h00) && (gap == 2'h3);
	assign tick_busy = (left != 8'h00);

	always_ff @(posedge aclk) begin
		if (tick_load) begin
			left <= tick_total;
			gap  <= 2'h0;
		end else if (left != 8'h00) begin
			gap <= gap + 2'h1;
			if (slow_tick) begin
				left <= left - 8'h01;
			end
		end
	end

	// Each pulse stands one cycle, so it is counted at the edge where it stands.
	always_ff @(posedge aclk) begin
		for (int i = 0; i < 5; i++) begin
			if (count_clear) begin
				seen[i] <= 8'h00;
			end else if (events[i]) begin
				seen[i] <= seen[i] + 8'h01;
			end
		end
	end
endmodule

// >>> testbench.sv
/*
 * Self-checking testbench for the periodic reset wake-up timer.
 * Assumes the register byte addresses below and the partner model for ticks.
 */
`timescale 1ns/10ps

`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end

module testbench;
	import prwt_pkg::*;

	localparam logic [7:0] A_RST  = 8'he8;
	localparam logic [7:0] A_WAKE = 8'he4;
	localparam logic [7:0] A_DIV  = 8'h00;
	localparam logic [7:0] A_NONE = 8'h10;
	localparam int         EV_WU  = 4;
	localparam int         EV_PR  = 3;
	localparam int         EV_CR  = 2;
	localparam int         EV_PX  = 1;
	localparam int         EV_PO  = 0;

	logic             aclk         = 1'b0;
	logic             aresetn      = 1'b0;
	logic             por_n        = 1'b0;
	logic             awvalid      = 1'b0;
	logic             wvalid       = 1'b0;
	logic             bready       = 1'b0;
	logic             arvalid      = 1'b0;
	logic             rready       = 1'b0;
	logic [7:0]       awaddr       = 8'h00;
	logic [7:0]       araddr       = 8'h00;
	logic [31:0]      wdata        = 32'h0000_0000;
	logic [3:0]       wstrb        = 4'hf;
	logic             debug_active = 1'b0;
	logic             unmask       = 1'b0;
	logic             tick_load    = 1'b0;
	logic             count_clear  = 1'b0;
	logic [7:0]       tick_total   = 8'h00;
	prwt_mode_t       power_mode   = PRWT_MODE_RUN_WAIT;
	logic             awready, wready, bvalid, arready, rvalid, tick_busy, slow_tick;
	logic [1:0]       bresp, rresp, last_bresp, last_rresp;
	logic [31:0]      rdata, last_rdata;
	prwt_event_t      events;
	logic [4:0][7:0]  seen;
	int               miscompares  = 0;
	int               comparisons  = 0;

	always #20 aclk = ~aclk;

	prwt_timer dut (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.slow_tick(slow_tick), .power_mode(power_mode), .debug_active(debug_active),
		.interrupt_unmask_instruction(unmask), .events(events));

	prwt_partner partner (.aclk(aclk), .tick_load(tick_load), .tick_total(tick_total),
		.tick_busy(tick_busy), .slow_tick(slow_tick), .events(events),
		.count_clear(count_clear), .seen(seen));

	// -----------------------------------------------------------------
	// Bus and stimulus tasks
	// -----------------------------------------------------------------
	// Readies are looked at on the falling edge, where they have settled.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_pend, w_pend, aw_hs, w_hs;
		aw_pend = 1'b1;
		w_pend  = 1'b1;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		bready  <= 1'b1;
		while (aw_pend || w_pend) begin
			@(negedge aclk);
			aw_hs = aw_pend && awready;
			w_hs  = w_pend && wready;
			@(posedge aclk);
			if (aw_hs) begin
				awvalid <= 1'b0;
				aw_pend = 1'b0;
			end
			if (w_hs) begin
				wvalid <= 1'b0;
				w_pend = 1'b0;
			end
		end
		do @(negedge aclk); while (bvalid !== 1'b1);
		last_bresp = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		last_rdata = rdata;
		last_rresp = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		`CHK("read data", e, last_rdata)
	endtask

	task automatic ev_chk(input int i, input logic [7:0] e);
		`CHK("event count", e, seen[i])
	endtask

	// Clears the event counts, then sends n ticks and lets the events land.
	task automatic ticks(input logic [7:0] n);
		@(posedge aclk);
		tick_load   <= 1'b1;
		tick_total  <= n;
		count_clear <= 1'b1;
		@(posedge aclk);
		tick_load   <= 1'b0;
		count_clear <= 1'b0;
		do @(negedge aclk); while (tick_busy);
		repeat (4) @(posedge aclk);
	endtask

	task automatic pulse_reset(input logic por);
		@(posedge aclk);
		aresetn <= 1'b0;
		por_n   <= !por;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		por_n   <= 1'b1;
	endtask

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task automatic t_basic();
		rd_chk(A_RST, 32'h0000_003f);
		rd(A_NONE);
		`CHK("read response", PRWT_AXI_DECERR, last_rresp)
	endtask

	task automatic t_count();
		wr(A_DIV, 32'h0000_0000);
		wr(A_WAKE, 32'h0000_0002);
		wr(A_RST, 32'h0000_0003);
		ticks(8'h0c);
		ev_chk(EV_WU, 8'h06);
		ev_chk(EV_PR, 8'h02);
		rd_chk(A_RST, 32'h0000_0083);
		rd_chk(A_WAKE, 32'h0000_0082);
	endtask

	task automatic t_flag();
		wr(A_RST, 32'h0000_0003);
		rd_chk(A_RST, 32'h0000_0083);
		wr(A_RST, 32'h0000_0043);
		rd_chk(A_RST, 32'h0000_0003);
		wr(A_RST, 32'h0000_0083);
		rd_chk(A_RST, 32'h0000_0003);
	endtask

	task automatic t_restart();
		ticks(8'h03);
		wr(A_RST, 32'h0000_0003);
		ticks(8'h03);
		ev_chk(EV_PR, 8'h01);
		ticks(8'h03);
		wr(A_RST, 32'h0000_0002);
		ticks(8'h03);
		ev_chk(EV_PR, 8'h00);
		ticks(8'h01);
		ev_chk(EV_PR, 8'h01);
	endtask

	task automatic t_zero();
		wr(A_RST, 32'h0000_0000);
		rd_chk(A_RST, 32'h0000_0080);
		ticks(8'h08);
		ev_chk(EV_WU, 8'h04);
		ev_chk(EV_PR, 8'h00);
		wr(A_RST, 32'h0000_0003);
		wr(A_WAKE, 32'h0000_0000);
		wr(A_RST, 32'h0000_0000);
		`CHK("write response", PRWT_AXI_OKAY, last_bresp)
		rd_chk(A_RST, 32'h0000_0083);
		wr(A_WAKE, 32'h0000_0002);
		// The zero wake-up interval forced the divider to full scale; later scenarios count single ticks.
		wr(A_DIV, 32'h0000_0000);
	endtask

	task automatic t_debug();
		ticks(8'h03);
		@(posedge aclk);
		debug_active <= 1'b1;
		ticks(8'h06);
		ev_chk(EV_WU, 8'h00);
		ev_chk(EV_PR, 8'h00);
		@(posedge aclk);
		debug_active <= 1'b0;
		ticks(8'h03);
		ev_chk(EV_PR, 8'h01);
	endtask

	task automatic t_modes();
		wr(A_RST, 32'h0000_0043);
		@(posedge aclk);
		power_mode <= PRWT_MODE_LIGHT_STOP;
		ticks(8'h06);
		ev_chk(EV_PR, 8'h01);
		`CHK("clock restart", 1'b1, seen[EV_CR] != 8'h00)
		rd_chk(A_RST, 32'h0000_0083);
		@(posedge aclk);
		power_mode <= PRWT_MODE_DEEP_STOP;
		ticks(8'h06);
		ev_chk(EV_PO, 8'h01);
		`CHK("power-on exit", 1'b1, seen[EV_PX] != 8'h00)
		@(posedge aclk);
		power_mode <= PRWT_MODE_RUN_WAIT;
		ticks(8'h00);
		ev_chk(EV_WU, 8'h00);
		@(posedge aclk);
		unmask <= 1'b1;
		@(posedge aclk);
		unmask <= 1'b0;
		repeat (3) @(posedge aclk);
		ev_chk(EV_WU, 8'h01);
	endtask

	task automatic t_resets();
		pulse_reset(1'b0);
		rd_chk(A_RST, 32'h0000_00bf);
		pulse_reset(1'b1);
		rd_chk(A_RST, 32'h0000_003f);
	endtask

	task automatic test_done();
		if (miscompares == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		por_n   <= 1'b1;
		t_basic();
		t_count();
		t_flag();
		t_restart();
		t_zero();
		t_debug();
		t_modes();
		t_resets();
		test_done();
	end

	// The whole sequence needs well under a thousand cycles; this bounds a hang.
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		test_done();
	end
endmodule
